// File: inc/pin_mux_cfg.svh
// offsets, field positions and reset values of the pin mux registers
// assumes a 32-bit register bus with one aligned word per register
`ifndef PIN_MUX_CFG_SVH
`define PIN_MUX_CFG_SVH

// register indices; byte address is four times the index
`define CKSEL_IDX 8'h0A
`define PC_GPS_IDX 8'h0B
`define PB_PER_IDX 8'h10
`define PC_PER_IDX 8'h11
`define PC_DIR_IDX 8'h12
`define TMR_OE_IDX 8'h13
`define PC_DATA_IDX 8'h14
`define PC_PIN_IDX 8'h15
`define REG_ADDR(idx) (8'((idx) * 4))

// clock_output_select fields
`define CKSEL_ALT_LSB 6
`define CKSEL_DIS_BIT 5
`define CKSEL_SRC_MSB 4
`define CKSEL_USED_W 10
`define CKSEL_RST 10'h020

// per-pin control reset values
`define PC_GPS_RST 4'h0
`define PB_PER_RST 4'hF
`define PC_PER_RST 4'hF
`define PC_DIR_RST 4'h0
`define TMR_OE_RST 4'h0
`define PC_DATA_RST 4'h0

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: inc/pin_mux_pkg.sv
// types shared by the pin mux block
// assumes pin_mux_cfg.svh for the numeric layout
`default_nettype none
package pin_mux_pkg;
    // clock output source codes that route a real clock
    typedef enum logic [4:0] {
        SRC_SYS = 5'h00,
        SRC_OSC = 5'h07,
        SRC_SYNTH = 5'h08,
        SRC_ADCA = 5'h10,
        SRC_ADCB = 5'h11
    } clk_src_type;
endpackage
`default_nettype wire

// File: rtl/axil_slave.sv
// axi4-lite slave front end: one write and one read under way at a time
// assumes the register file decodes addresses and answers combinationally
`default_nettype none
`include "pin_mux_cfg.svh"
module axil_slave (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // write address and data
    input wire logic [7:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    // write response
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    // read address and data
    input wire logic [7:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    // register file side
    output logic wr_en_out,
    output logic [7:0] wr_addr_out,
    output logic [31:0] wr_data_out,
    output logic [3:0] wr_strb_out,
    input wire logic wr_ok_in,
    output logic [7:0] rd_addr_out,
    input wire logic [31:0] rd_data_in,
    input wire logic rd_ok_in
);
    logic aw_q, w_q, ar_q;
    wire aw_hs = awvalid_in & awready_out;
    wire w_hs = wvalid_in & wready_out;
    wire ar_hs = arvalid_in & arready_out;
    wire rd_en = ar_q & ~rvalid_out;

    // write fires once address and data are both held
    assign wr_en_out = aw_q & w_q & ~bvalid_out;

    // write channel: address and data taken in either order
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awready_out <= 1'b0;
            wready_out <= 1'b0;
            bvalid_out <= 1'b0;
            bresp_out <= `RESP_OKAY;
            wr_addr_out <= 8'h00;
            wr_data_out <= 32'h0000_0000;
            wr_strb_out <= 4'h0;
        end else begin
            if (aw_hs) begin
                aw_q <= 1'b1;
                wr_addr_out <= awaddr_in;
            end else if (wr_en_out) begin
                aw_q <= 1'b0;
            end
            if (w_hs) begin
                w_q <= 1'b1;
                wr_data_out <= wdata_in;
                wr_strb_out <= wstrb_in;
            end else if (wr_en_out) begin
                w_q <= 1'b0;
            end
            awready_out <= ~aw_hs & ~aw_q & ~bvalid_out & ~awready_out ? 1'b1
                : awready_out & ~aw_hs;
            wready_out <= ~w_hs & ~w_q & ~bvalid_out & ~wready_out ? 1'b1
                : wready_out & ~w_hs;
            if (wr_en_out) begin
                bvalid_out <= 1'b1;
                bresp_out <= wr_ok_in ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bready_in) begin
                bvalid_out <= 1'b0;
            end
        end
    end

    // read channel: data registered one edge after the address
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ar_q <= 1'b0;
            arready_out <= 1'b0;
            rvalid_out <= 1'b0;
            rdata_out <= 32'h0000_0000;
            rresp_out <= `RESP_OKAY;
            rd_addr_out <= 8'h00;
        end else begin
            if (ar_hs) begin
                ar_q <= 1'b1;
                rd_addr_out <= araddr_in;
            end else if (rd_en) begin
                ar_q <= 1'b0;
            end
            arready_out <= ~ar_hs & ~ar_q & ~rvalid_out & ~arready_out ? 1'b1
                : arready_out & ~ar_hs;
            if (rd_en) begin
                rvalid_out <= 1'b1;
                rdata_out <= rd_ok_in ? rd_data_in : 32'h0000_0000;
                rresp_out <= rd_ok_in ? `RESP_OKAY : `RESP_SLVERR;
            end else if (rready_in) begin
                rvalid_out <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// File: rtl/clock_out_and_port_function_mux.sv
// clock output select and port b / port c pin function multiplexer
// assumes pads resolve level from out and active-low output enable
//
// Function
// - bits 15..10 of clock select read zero
// - clock output source resets to system clock
// - port b gpio mode overrides alternate selection
// - pin b7: address 23 or master oscillator
// - pin b6: address 22 or doubled clock
// - pin b5: address 21 or system clock
// - pin b4: address 20 or prescaler reference
// - disable bit tri-states clock pin, resets one
// - codes 00000, 10000, 10001 route sys, adc clocks
// - code 00111 oscillator, 01000 synthesizer output
// - factory test codes reserved, unused by software
// - port c enable zero gives gpio, direction
// - select bit picks decoder/timer or spi
// - timer enable: input only or driven output
// - each port c pin controlled independently
// - port c resets to decoder/timer function
// - spi mode direction comes from spi controller
// - select register: four bits, upper read zero
`default_nettype none
`include "pin_mux_cfg.svh"
module clock_out_and_port_function_mux (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // axi4-lite register bus
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // clock sources, foreign domains
    input wire logic system_clock_in,
    input wire logic system_clock_doubled_in,
    input wire logic master_oscillator_clock_in,
    input wire logic prescaler_reference_clock_in,
    input wire logic synthesizer_output_clock_in,
    input wire logic raw_oscillator_clock_in,
    input wire logic converter_a_clock_in,
    input wire logic converter_b_clock_in,
    // clock output pin
    output logic clock_output_pin_out,
    output logic clock_output_pin_oe_n_out,
    // port b upper pins 7..4 (index 3..0)
    input wire logic [3:0] address_line_in,
    input wire logic [3:0] port_b_gpio_data_in,
    input wire logic [3:0] port_b_gpio_oe_n_in,
    output logic [3:0] port_b_pin_out,
    output logic [3:0] port_b_pin_oe_n_out,
    // port c pins 3..0
    input wire logic [3:0] port_c_pin_in,
    output logic [3:0] port_c_pin_out,
    output logic [3:0] port_c_pin_oe_n_out,
    // port c peripheral side
    input wire logic [3:0] timer_out_in,
    input wire logic [3:0] spi_out_in,
    input wire logic [3:0] spi_oe_n_in,
    output logic [3:0] decoder_timer_in_out,
    output logic [3:0] spi_in_out
);
    // register file side of the bus slave
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic wr_ok, rd_ok;

    // control registers
    logic [`CKSEL_USED_W-1:0] cksel_q, cksel_d;
    logic [3:0] pc_gps_q, pc_gps_d;
    logic [3:0] pb_per_q, pb_per_d;
    logic [3:0] pc_per_q, pc_per_d;
    logic [3:0] pc_dir_q, pc_dir_d;
    logic [3:0] tmr_oe_q, tmr_oe_d;
    logic [3:0] pc_data_q, pc_data_d;
    logic [3:0] pc_pin_q;
    // synchronised foreign levels
    logic [11:0] sync_q;
    wire [7:0] src = sync_q[7:0];
    wire [3:0] pc_pin_s = sync_q[11:8];
    axil_slave axil_slave_inst (
        .clk_in(mclk_in),
        .rst_in(rst_in),
        .awaddr_in(s_axi_awaddr_in),
        .awvalid_in(s_axi_awvalid_in),
        .awready_out(s_axi_awready_out),
        .wdata_in(s_axi_wdata_in),
        .wstrb_in(s_axi_wstrb_in),
        .wvalid_in(s_axi_wvalid_in),
        .wready_out(s_axi_wready_out),
        .bresp_out(s_axi_bresp_out),
        .bvalid_out(s_axi_bvalid_out),
        .bready_in(s_axi_bready_in),
        .araddr_in(s_axi_araddr_in),
        .arvalid_in(s_axi_arvalid_in),
        .arready_out(s_axi_arready_out),
        .rdata_out(s_axi_rdata_out),
        .rresp_out(s_axi_rresp_out),
        .rvalid_out(s_axi_rvalid_out),
        .rready_in(s_axi_rready_in),
        .wr_en_out(wr_en),
        .wr_addr_out(wr_addr),
        .wr_data_out(wr_data),
        .wr_strb_out(wr_strb),
        .wr_ok_in(wr_ok),
        .rd_addr_out(rd_addr),
        .rd_data_in(rd_data),
        .rd_ok_in(rd_ok)
    );
    sync_2ff #(
        .WIDTH(12)
    ) sync_2ff_inst (
        .clk_in(mclk_in),
        .rst_in(rst_in),
        .d_in({port_c_pin_in, converter_b_clock_in, converter_a_clock_in,
               raw_oscillator_clock_in, synthesizer_output_clock_in,
               prescaler_reference_clock_in, master_oscillator_clock_in,
               system_clock_doubled_in, system_clock_in}),
        .q_out(sync_q)
    );

    // write decode
    wire hit_cksel = wr_addr == `REG_ADDR(`CKSEL_IDX);
    wire hit_gps = wr_addr == `REG_ADDR(`PC_GPS_IDX);
    wire hit_pbper = wr_addr == `REG_ADDR(`PB_PER_IDX);
    wire hit_pcper = wr_addr == `REG_ADDR(`PC_PER_IDX);
    wire hit_dir = wr_addr == `REG_ADDR(`PC_DIR_IDX);
    wire hit_oe = wr_addr == `REG_ADDR(`TMR_OE_IDX);
    wire hit_data = wr_addr == `REG_ADDR(`PC_DATA_IDX);
    wire hit_pin = wr_addr == `REG_ADDR(`PC_PIN_IDX);
    assign wr_ok = hit_cksel | hit_gps | hit_pbper | hit_pcper | hit_dir
        | hit_oe | hit_data | hit_pin;
    // byte lanes: low lane bits 7..0, next lane bits 15..8
    wire lane0 = wr_strb[0];
    wire lane1 = wr_strb[1];
    wire [1:0] cksel_hi_w = wr_data[9:8];
    wire [7:0] cksel_lo_w = wr_data[7:0];
    wire [3:0] nib_w = wr_data[3:0];
    // next values; bits 15..10 are never stored
    assign cksel_d = {(wr_en & hit_cksel & lane1) ? cksel_hi_w : cksel_q[9:8],
                      (wr_en & hit_cksel & lane0) ? cksel_lo_w : cksel_q[7:0]};
    assign pc_gps_d = (wr_en & hit_gps & lane0) ? nib_w : pc_gps_q;
    assign pb_per_d = (wr_en & hit_pbper & lane0) ? nib_w : pb_per_q;
    assign pc_per_d = (wr_en & hit_pcper & lane0) ? nib_w : pc_per_q;
    assign pc_dir_d = (wr_en & hit_dir & lane0) ? nib_w : pc_dir_q;
    assign tmr_oe_d = (wr_en & hit_oe & lane0) ? nib_w : tmr_oe_q;
    assign pc_data_d = (wr_en & hit_data & lane0) ? nib_w : pc_data_q;

    // control register update; reset picks sys clock, pin off, decoder
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            cksel_q <= `CKSEL_RST;
            pc_gps_q <= `PC_GPS_RST;
            pb_per_q <= `PB_PER_RST;
            pc_per_q <= `PC_PER_RST;
            pc_dir_q <= `PC_DIR_RST;
            tmr_oe_q <= `TMR_OE_RST;
            pc_data_q <= `PC_DATA_RST;
            pc_pin_q <= 4'h0;
        end else begin
            cksel_q <= cksel_d;
            pc_gps_q <= pc_gps_d;
            pb_per_q <= pb_per_d;
            pc_per_q <= pc_per_d;
            pc_dir_q <= pc_dir_d;
            tmr_oe_q <= tmr_oe_d;
            pc_data_q <= pc_data_d;
            pc_pin_q <= pc_pin_s;
        end
    end

    // read decode; unused upper bits read zero
    wire rd_cksel = rd_addr == `REG_ADDR(`CKSEL_IDX);
    wire rd_gps = rd_addr == `REG_ADDR(`PC_GPS_IDX);
    wire rd_pbper = rd_addr == `REG_ADDR(`PB_PER_IDX);
    wire rd_pcper = rd_addr == `REG_ADDR(`PC_PER_IDX);
    wire rd_dir = rd_addr == `REG_ADDR(`PC_DIR_IDX);
    wire rd_oe = rd_addr == `REG_ADDR(`TMR_OE_IDX);
    wire rd_dat = rd_addr == `REG_ADDR(`PC_DATA_IDX);
    wire rd_pin = rd_addr == `REG_ADDR(`PC_PIN_IDX);
    wire [3:0] rd_nib = rd_gps ? pc_gps_q
        : rd_pbper ? pb_per_q
        : rd_pcper ? pc_per_q
        : rd_dir ? pc_dir_q
        : rd_oe ? tmr_oe_q
        : rd_dat ? pc_data_q
        : rd_pin ? pc_pin_q
        : 4'h0;
    assign rd_ok = rd_cksel | rd_gps | rd_pbper | rd_pcper | rd_dir | rd_oe
        | rd_dat | rd_pin;
    assign rd_data = rd_cksel ? {22'h0, cksel_q} : {28'h000_0000, rd_nib};
    // clock output source select; reserved test codes give low
    wire [4:0] sel = cksel_q[`CKSEL_SRC_MSB:0];
    wire clk_pick = (sel == pin_mux_pkg::SRC_SYS) ? src[0]
        : (sel == pin_mux_pkg::SRC_ADCA) ? src[6]
        : (sel == pin_mux_pkg::SRC_ADCB) ? src[7]
        : (sel == pin_mux_pkg::SRC_OSC) ? src[5]
        : (sel == pin_mux_pkg::SRC_SYNTH) ? src[4]
        : 1'b0;
    wire clk_oe_n = cksel_q[`CKSEL_DIS_BIT];
    // alternate clocks for pins b7..b4: master osc, doubled, sys, prescaler
    wire [3:0] alt_clk = {src[2], src[1], src[0], src[3]};
    wire [3:0] alt_sel = cksel_q[`CKSEL_ALT_LSB+3:`CKSEL_ALT_LSB];
    logic [3:0] pb_out_d, pb_oe_n_d;
    logic [3:0] pc_out_d, pc_oe_n_d, dec_in_d, spi_in_d;

    // per-pin multiplexers, each pin with its own controls
    for (genvar i = 0; i < 4; i++) begin : g_pin
        // address line or alternate clock, per bit
        wire pb_periph = alt_sel[i] ? alt_clk[i] : address_line_in[i];
        // gpio wins whenever the peripheral enable is clear
        assign pb_out_d[i] = pb_per_q[i] ? pb_periph : port_b_gpio_data_in[i];
        assign pb_oe_n_d[i] = pb_per_q[i] ? 1'b0 : port_b_gpio_oe_n_in[i];

        wire is_gpio = ~pc_per_q[i];
        wire is_spi = pc_per_q[i] & pc_gps_q[i];
        wire is_tmr = pc_per_q[i] & ~pc_gps_q[i];
        // gpio: direction bit, one drives the pad
        // timer: enable bit drives, decoder still samples
        // spi: direction from spi controller
        assign pc_out_d[i] = is_gpio ? pc_data_q[i]
            : is_spi ? spi_out_in[i] : timer_out_in[i];
        assign pc_oe_n_d[i] = is_gpio ? ~pc_dir_q[i]
            : is_spi ? spi_oe_n_in[i] : ~tmr_oe_q[i];
        assign dec_in_d[i] = is_tmr & pc_pin_s[i];
        assign spi_in_d[i] = is_spi & pc_pin_s[i];
    end

    // every pin output is registered
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            clock_output_pin_out <= 1'b0;
            clock_output_pin_oe_n_out <= 1'b1;
            port_b_pin_out <= 4'h0;
            port_b_pin_oe_n_out <= 4'hF;
            port_c_pin_out <= 4'h0;
            port_c_pin_oe_n_out <= 4'hF;
            decoder_timer_in_out <= 4'h0;
            spi_in_out <= 4'h0;
        end else begin
            clock_output_pin_out <= clk_pick;
            clock_output_pin_oe_n_out <= clk_oe_n;
            port_b_pin_out <= pb_out_d;
            port_b_pin_oe_n_out <= pb_oe_n_d;
            port_c_pin_out <= pc_out_d;
            port_c_pin_oe_n_out <= pc_oe_n_d;
            decoder_timer_in_out <= dec_in_d;
            spi_in_out <= spi_in_d;
        end
    end
endmodule
`default_nettype wire

// File: rtl/sync_2ff.sv
// two flip-flop synchroniser for a vector of independent levels
// assumes each bit may change at any time relative to clk_in
`default_nettype none
module sync_2ff #(
    parameter int WIDTH = 12
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // data
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_q;

    // first stage is read only by the second
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_q <= '0;
            q_out <= '0;
        end else begin
            meta_q <= d_in;
            q_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// File: tb/pad_model.sv
// pad and clock source model facing the pin mux
// assumes pull-ups on released pads and static source levels set by the bench
`default_nettype none
module pad_model (
    // source levels and external drive from the bench
    input wire logic [7:0] src_level_in,
    input wire logic [3:0] ext_drive_in,
    input wire logic [3:0] ext_level_in,
    // design pins
    input wire logic clk_pin_in,
    input wire logic clk_oe_n_in,
    input wire logic [3:0] pc_pin_in,
    input wire logic [3:0] pc_oe_n_in,
    // resolved levels
    output logic [7:0] src_clock_out,
    output logic clk_pad_out,
    output logic [3:0] pc_pad_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // sources follow the requested levels
    assign src_clock_out = src_level_in;
    // released pads float up to the pull-up level
    assign clk_pad_out = clk_oe_n_in ? 1'h1 : clk_pin_in;
    assign pc_pad_out = (~pc_oe_n_in & pc_pin_in) | (pc_oe_n_in & ~ext_drive_in)
        | (pc_oe_n_in & ext_drive_in & ext_level_in);
endmodule
`default_nettype wire

// File: tb/pin_mux_chk.sv
// concurrent checks on the pin mux ports
// assumes binding into the pin mux top module, one clock domain
`default_nettype none
module pin_mux_chk (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // register bus
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [1:0] s_axi_rresp_out,
    input wire logic s_axi_rvalid_out,
    // pins
    input wire logic clock_output_pin_oe_n_out,
    input wire logic [3:0] port_b_gpio_oe_n_in,
    input wire logic [3:0] port_b_pin_oe_n_out,
    input wire logic [3:0] port_c_pin_oe_n_out,
    input wire logic [3:0] spi_oe_n_in,
    input wire logic [3:0] spi_in_out,
    input wire logic [3:0] decoder_timer_in_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rd_addr_q;
    logic rd_cksel;
    default clocking tick @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // address of the read under way
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rd_addr_q <= 8'h00;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            rd_addr_q <= s_axi_araddr_in;
        end
    end
    assign rd_cksel = s_axi_rvalid_out && rd_addr_q == 8'h28;
    AST_RST_PINS: assert property ($fell(rst_in) |-> clock_output_pin_oe_n_out
        && port_c_pin_oe_n_out == 4'hF && port_b_pin_oe_n_out == 4'hF)
        else $error("pins driven at reset release");
    AST_CKSEL_UPPER: assert property (rd_cksel |-> s_axi_rdata_out[31:10] == 22'h0)
        else $error("clock select upper bits not zero");
    AST_CKSEL_DIS: assert property (
        rd_cksel && s_axi_rresp_out == 2'h0 |-> clock_output_pin_oe_n_out == s_axi_rdata_out[5])
        else $error("clock pin enable differs from disable bit");
    AST_GPS_UPPER: assert property (
        s_axi_rvalid_out && rd_addr_q == 8'h2C |-> s_axi_rdata_out[31:4] == 28'h0)
        else $error("select register upper bits not zero");
    AST_ERR_ZERO: assert property (s_axi_rvalid_out && s_axi_rresp_out == 2'h2
        |-> s_axi_rdata_out == 32'h0)
        else $error("refused read returned data");
    AST_RD_LAT: assert property (s_axi_arvalid_in && s_axi_arready_out |-> ##[1:2] s_axi_rvalid_out)
        else $error("read answer late");
    AST_WR_LAT: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
        && s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out)
        else $error("write answer late");
    AST_C_EXCL: assert property ((spi_in_out & decoder_timer_in_out) == 4'h0)
        else $error("pin routed to both decoder and spi");
    AST_B_RELEASE: assert property (!$past(rst_in) |->
        (port_b_pin_oe_n_out & ~$past(port_b_gpio_oe_n_in)) == 4'h0)
        else $error("port b released while gpio drives");
    AST_SPI_DIR: assert property (
        (~port_c_pin_oe_n_out & spi_in_out & $past(spi_oe_n_in)) == 4'h0)
        else $error("spi pin driven against spi direction");
    // main scenarios
    cover property (rd_cksel);
    cover property (spi_in_out != 4'h0);
    cover property (s_axi_rvalid_out && s_axi_rresp_out == 2'h2);
endmodule
bind clock_out_and_port_function_mux pin_mux_chk pin_mux_chk_inst (.*);
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the clock output and port function mux
// assumes the pad model and the checker file are compiled before it
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in = 1'h0;
    logic rst_in = 1'h1;
    logic [7:0] s_axi_awaddr_in, s_axi_araddr_in, src_level;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
    logic [3:0] s_axi_wstrb_in;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
    logic s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    logic s_axi_rvalid_out, clock_output_pin_out, clock_output_pin_oe_n_out, clk_pad;
    wire system_clock_in, system_clock_doubled_in, master_oscillator_clock_in;
    wire prescaler_reference_clock_in, synthesizer_output_clock_in, raw_oscillator_clock_in;
    wire converter_a_clock_in, converter_b_clock_in;
    logic [3:0] address_line_in, port_b_gpio_data_in, port_b_gpio_oe_n_in, port_b_pin_out;
    logic [3:0] port_b_pin_oe_n_out, port_c_pin_in, port_c_pin_out, port_c_pin_oe_n_out;
    logic [3:0] timer_out_in, spi_out_in, spi_oe_n_in, decoder_timer_in_out, spi_in_out;
    logic [3:0] ext_drive, ext_level;
    logic [4:0] codes [5] = '{pin_mux_pkg::SRC_SYS, pin_mux_pkg::SRC_OSC, pin_mux_pkg::SRC_SYNTH,
        pin_mux_pkg::SRC_ADCA, pin_mux_pkg::SRC_ADCB};
    int srcs [5] = '{0, 5, 4, 6, 7};
    int fails = 0;
    int samples_checked = 0;
    always #25 mclk_in = ~mclk_in;
    clock_out_and_port_function_mux clock_out_and_port_function_mux_inst (.*);
    pad_model pad_model_inst (
        .src_level_in(src_level), .ext_drive_in(ext_drive), .ext_level_in(ext_level),
        .clk_pin_in(clock_output_pin_out), .clk_oe_n_in(clock_output_pin_oe_n_out),
        .pc_pin_in(port_c_pin_out), .pc_oe_n_in(port_c_pin_oe_n_out),
        .src_clock_out({converter_b_clock_in, converter_a_clock_in, raw_oscillator_clock_in,
            synthesizer_output_clock_in, prescaler_reference_clock_in,
            master_oscillator_clock_in, system_clock_doubled_in, system_clock_in}),
        .clk_pad_out(clk_pad), .pc_pad_out(port_c_pin_in));
    // verdict and end of run
    task automatic complete_run;
        if (fails == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // one comparison of a settled value
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // missing bus answer ends the run
    task automatic hang;
        fails++;
        $display("unexpected at %0t: no bus answer", $time);
        complete_run();
    endtask
    // let pins follow; sync path takes three edges
    task automatic settle;
        repeat (6) @(posedge mclk_in);
    endtask
    // one write, response compared
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge mclk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_wstrb_in <= 4'hF;
        s_axi_awvalid_in <= 1'h1;
        s_axi_wvalid_in <= 1'h1;
        s_axi_bready_in <= 1'h1;
        do begin
            @(posedge mclk_in);
            n++;
            if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
            if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
        end while (!s_axi_bvalid_out && n < 50);
        s_axi_bready_in <= 1'h0;
        compare(s_axi_bresp_out, r);
        if (n >= 50) hang();
    endtask
    // one read, data and response compared
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge mclk_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'h1;
        s_axi_rready_in <= 1'h1;
        do begin
            @(posedge mclk_in);
            n++;
            if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
        end while (!s_axi_rvalid_out && n < 50);
        s_axi_rready_in <= 1'h0;
        compare(s_axi_rdata_out, d);
        compare(s_axi_rresp_out, r);
        if (n >= 50) hang();
    endtask
    // reset, then the sequences
    initial begin
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
        {s_axi_arvalid_in, s_axi_rready_in, s_axi_wstrb_in} = 6'h00;
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 48'h0;
        {address_line_in, port_b_gpio_data_in, timer_out_in, spi_out_in} = 16'h0;
        {port_b_gpio_oe_n_in, spi_oe_n_in, ext_drive, ext_level} = 16'hFF00;
        src_level = 8'h00;
        repeat (12) @(posedge mclk_in);
        rst_in <= 1'h0;
        settle();
        rd(8'h28, 32'h20, 2'h0);
        rd(8'h2C, 32'h0, 2'h0);
        compare(clk_pad, 1'h1);
        compare(decoder_timer_in_out, 4'hF);
        compare(spi_in_out, 4'h0);
        wr(8'h28, 32'hFFFF_FFC0, 2'h0);
        rd(8'h28, 32'h3C0, 2'h0);
        // routed codes only, each source high then low
        for (int i = 0; i < 5; i++) begin
            wr(8'h28, {27'h0, codes[i]}, 2'h0);
            src_level <= 8'h01 << srcs[i];
            settle();
            compare(clk_pad, 1'h1);
            src_level <= ~(8'h01 << srcs[i]);
            settle();
            compare(clk_pad, 1'h0);
        end
        wr(8'h28, 32'h31, 2'h0);
        settle();
        compare({clock_output_pin_oe_n_out, clk_pad}, 2'h3);
        // port b: address lines, alternate clocks, gpio override
        address_line_in <= 4'h5;
        src_level <= 8'h05;
        wr(8'h40, 32'hF, 2'h0);
        wr(8'h28, 32'h0, 2'h0);
        settle();
        compare({port_b_pin_oe_n_out, port_b_pin_out}, 8'h05);
        wr(8'h28, 32'h3C0, 2'h0);
        settle();
        compare(port_b_pin_out, 4'hA);
        address_line_in <= 4'hA;
        src_level <= 8'h0A;
        settle();
        compare(port_b_pin_out, 4'h5);
        port_b_gpio_data_in <= 4'h3;
        port_b_gpio_oe_n_in <= 4'hC;
        wr(8'h40, 32'h0, 2'h0);
        settle();
        compare({port_b_pin_oe_n_out, port_b_pin_out}, 8'hC3);
        // port c: gpio out, gpio in, timer out, spi out side by side
        timer_out_in <= 4'hF;
        spi_out_in <= 4'hF;
        spi_oe_n_in <= 4'h0;
        ext_drive <= 4'h2;
        wr(8'h44, 32'hC, 2'h0);
        wr(8'h48, 32'h9, 2'h0);
        wr(8'h50, 32'h1, 2'h0);
        wr(8'h2C, 32'hFFFF_FFF8, 2'h0);
        wr(8'h4C, 32'h4, 2'h0);
        settle();
        compare(port_c_pin_oe_n_out, 4'h2);
        compare(port_c_pin_in, 4'hD);
        compare(decoder_timer_in_out, 4'h4);
        compare(spi_in_out, 4'h8);
        rd(8'h2C, 32'h8, 2'h0);
        rd(8'h54, 32'hD, 2'h0);
        // spi input and timer input only
        spi_oe_n_in <= 4'hF;
        ext_drive <= 4'hE;
        ext_level <= 4'h4;
        wr(8'h4C, 32'h0, 2'h0);
        settle();
        compare(port_c_pin_oe_n_out, 4'hE);
        compare(decoder_timer_in_out, 4'h4);
        compare(spi_in_out, 4'h0);
        // unmapped address refused
        wr(8'h7C, 32'hFFFF_FFFF, 2'h2);
        rd(8'h7C, 32'h0, 2'h2);
        complete_run();
    end
endmodule
`default_nettype wire
